// File: src_rom_cmd_engine.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - No answer from the memory within 30 ms abandons the operation; back to idle.
// - An abandoned operation sets the time-out flag, command bit 9.
// - Data line pulled high with no memory: no time-out, busy clears at sequence end.
// - Data line low, no memory: only erase, erase-all, program, program-all time out.
// - Address-loaded flag, bit 8, set on valid load at power-up or reload; write one clears.
// - Command bits 7:0 hold the byte address used for the access; resets to zero.
// - Data register bits 7:0 hold read result or byte to write; resets to zero.
// - Data register bits 31:8 are reserved and read-only.
module src_rom_cmd_engine import src_pkg::*; #(
	parameter int TMO_CYC = TIMEOUT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rom_serial_data_line_i,
	output logic             rom_serial_data_line_o,
	output logic             rom_serial_data_line_oe,
	output logic             rom_cs,
	output logic             rom_sclk,
	output logic [47:0]      station_addr,
	output logic             irq
);
	// ****************************************
	// Declarations
	// ****************************************
	src_top_st_t st_ff;
	logic [2:0]  cmd_ff;
	logic [7:0]  addr_ff;
	logic [7:0]  data_ff;
	logic        tmo_flag_ff;
	logic        loaded_ff;
	logic [2:0]  ld_idx_ff;
	logic [2:0]  irq_stat_ff;
	logic [2:0]  irq_mask_ff;
	logic        start_ff;
	src_op_t     op_ff;
	logic        sdi;
	logic        eng_done;
	logic        eng_tmo;
	logic [7:0]  eng_rdata;
	src_pins_t   pins;
	logic        busy;
	logic        req;
	logic        wr;
	logic        wr_cmd;
	logic        go;
	logic        ev_done;
	logic        ev_tmo;
	logic        ev_loaded;
	logic        ld_store;

	// ****************************************
	// Link side
	// ****************************************
	src_sync2 u_sync (
		.mclk (mclk),
		.rst_n(rst_n),
		.d    (rom_serial_data_line_i),
		.q    (sdi)
	);

	src_serial_engine #(.TMO_CYC(TMO_CYC)) u_eng (
		.mclk (mclk),
		.rst_n(rst_n),
		.start(start_ff),
		.op   (op_ff),
		.sdi  (sdi),
		.done (eng_done),
		.tmo  (eng_tmo),
		.rdata(eng_rdata),
		.pins (pins)
	);

	assign rom_cs                  = pins.cs;
	assign rom_sclk                = pins.sclk;
	assign rom_serial_data_line_o  = pins.dout;
	assign rom_serial_data_line_oe = pins.doe;

	// ****************************************
	// Bus decode
	// ****************************************
	assign req    = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign wr     = req & wb_ack_o & wb_we_i;
	assign wr_cmd = wr & (wb_adr_i == OFS_CMD);
	assign busy   = (st_ff != TOP_IDLE);
	assign go     = wr_cmd & wb_sel_i[3] & wb_dat_i[BIT_BUSY] & ~busy;

	assign ev_done   = eng_done & (st_ff == TOP_RUN || st_ff == TOP_LD_WAIT);
	assign ev_tmo    = eng_done & eng_tmo;
	assign ld_store  = (st_ff == TOP_LD_WAIT) & eng_done & ~eng_tmo &
	                   ((ld_idx_ff != 3'h0) | (eng_rdata == SIG_BYTE));
	assign ev_loaded = ld_store & (ld_idx_ff == LOAD_LAST);

	always_ff @(posedge mclk) begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req & ~wb_ack_o;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			wb_dat_o <= '0;
		else if (req & ~wb_ack_o) begin
			case (wb_adr_i)
				OFS_CMD:      wb_dat_o <= {busy, cmd_ff, 18'h0_0000, tmo_flag_ff, loaded_ff, addr_ff};
				OFS_DATA:     wb_dat_o <= {24'h00_0000, data_ff};
				OFS_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_stat_ff};
				OFS_IRQ_MASK: wb_dat_o <= {29'h0000_0000, irq_mask_ff};
				default:      wb_dat_o <= '0;
			endcase
		end
	end

	// ****************************************
	// Command and data registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_ff <= RST_BYTE;
			cmd_ff  <= CMD_READ;
		end else if (wr_cmd & ~busy) begin
			if (wb_sel_i[0])
				addr_ff <= wb_dat_i[7:0];
			if (wb_sel_i[3])
				cmd_ff <= wb_dat_i[CMD_LSB +: 3];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			data_ff <= RST_BYTE;
		else if (st_ff == TOP_RUN && eng_done && !eng_tmo && op_ff.cmd == CMD_READ)
			data_ff <= eng_rdata;
		else if (wr & (wb_adr_i == OFS_DATA) & wb_sel_i[0] & ~busy)
			data_ff <= wb_dat_i[7:0];
	end

	// ****************************************
	// Flags
	// ****************************************
	// Cleared by the next command; a time-out cannot coincide with acceptance
	always_ff @(posedge mclk) begin
		if (!rst_n)
			tmo_flag_ff <= 1'b0;
		else if (ev_tmo)
			tmo_flag_ff <= 1'b1;
		else if (go)
			tmo_flag_ff <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			loaded_ff <= 1'b0;
		else if (ev_loaded)
			loaded_ff <= 1'b1;
		else if (wr_cmd & wb_sel_i[1] & wb_dat_i[BIT_LOADED])
			loaded_ff <= 1'b0;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff     <= TOP_BOOT;
			ld_idx_ff <= 3'h0;
			start_ff  <= 1'b0;
			op_ff     <= '0;
		end else begin
			start_ff <= 1'b0;
			case (st_ff)
				// Station address is fetched once after reset
				TOP_BOOT: begin
					ld_idx_ff <= 3'h0;
					st_ff     <= TOP_LD_RD;
				end
				TOP_IDLE: if (go) begin
					if (wb_dat_i[CMD_LSB +: 3] == CMD_RELOAD) begin
						ld_idx_ff <= 3'h0;
						st_ff     <= TOP_LD_RD;
					end else begin
						op_ff    <= '{cmd: wb_dat_i[CMD_LSB +: 3],
						              addr: wb_sel_i[0] ? wb_dat_i[7:0] : addr_ff, data: data_ff};
						start_ff <= 1'b1;
						st_ff    <= TOP_RUN;
					end
				end
				TOP_RUN: if (eng_done)
					st_ff <= TOP_IDLE;
				TOP_LD_RD: begin
					op_ff    <= '{cmd: CMD_READ, addr: {5'h00, ld_idx_ff}, data: RST_BYTE};
					start_ff <= 1'b1;
					st_ff    <= TOP_LD_WAIT;
				end
				TOP_LD_WAIT: if (eng_done) begin
					if (!ld_store || ld_idx_ff == LOAD_LAST)
						st_ff <= TOP_IDLE;
					else begin
						ld_idx_ff <= ld_idx_ff + 3'h1;
						st_ff     <= TOP_LD_RD;
					end
				end
				default: st_ff <= TOP_IDLE;
			endcase
		end
	end

	// Commits each station address byte as it arrives, once the signature byte matched
	always_ff @(posedge mclk) begin
		if (!rst_n)
			station_addr <= '0;
		else if (ld_store && ld_idx_ff != 3'h0)
			station_addr[8 * (int'(ld_idx_ff) - 1) +: 8] <= eng_rdata;
	end

	// ****************************************
	// Interrupts
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_stat_ff <= RST_IRQ;
			irq_mask_ff <= RST_IRQ;
		end else begin
			// Set beats a same-cycle write-one clear
			irq_stat_ff <= (irq_stat_ff &
			               ~((wr & (wb_adr_i == OFS_IRQ_STAT) & wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0)) |
			               {ev_loaded, ev_tmo, ev_done};
			if (wr & (wb_adr_i == OFS_IRQ_MASK) & wb_sel_i[0])
				irq_mask_ff <= wb_dat_i[2:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_ff & irq_mask_ff);
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_TMO_SETS_FLAG: assert property (eng_done && eng_tmo |=> tmo_flag_ff)
		else $error("time-out did not set the flag");
	AST_TMO_IDLE: assert property (st_ff == TOP_RUN && eng_done |=> st_ff == TOP_IDLE && !busy)
		else $error("command did not return to idle");
	AST_ADDR_USED: assert property (start_ff && st_ff == TOP_RUN |-> op_ff.addr == addr_ff)
		else $error("engine address differs from register");
	AST_READ_DATA: assert property (st_ff == TOP_RUN && eng_done && !eng_tmo && op_ff.cmd == CMD_READ
		|=> data_ff == $past(eng_rdata))
		else $error("read byte not captured");
	AST_DATA_RSVD: assert property (wb_ack_o && wb_adr_i == OFS_DATA && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("reserved data bits not zero");
	AST_LOADED_SET: assert property (ev_loaded |=> loaded_ff ##1 loaded_ff || $past(wr_cmd))
		else $error("loaded flag not set");
	AST_BUSY_IGNORES: assert property (busy && wr_cmd |=> $stable(cmd_ff) && $stable(addr_ff))
		else $error("command register changed while busy");
	AST_BUSY_SPAN: assert property ($fell(busy) |-> $past(eng_done))
		else $error("busy dropped before the engine finished");
	AST_LOW_NO_TMO_READ: assert property (st_ff == TOP_RUN && eng_done && op_ff.cmd == CMD_READ |-> !eng_tmo)
		else $error("read command timed out");
	COV_TMO: cover property (ev_tmo && st_ff == TOP_RUN);
	COV_LOADED: cover property (ev_loaded);
	COV_READ: cover property (st_ff == TOP_RUN && eng_done && op_ff.cmd == CMD_READ);
	COV_IRQ: cover property ($rose(irq));
endmodule // src_rom_cmd_engine
`default_nettype wire

// File: src_pkg.sv
`default_nettype none
package src_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ        = 200;
	localparam int LINK_PERIOD_NS = 125;
	localparam int HALF_CYC       = (LINK_PERIOD_NS * CLK_MHZ + 1999) / 2000;
	localparam int TIMEOUT_MS     = 30;
	localparam int TIMEOUT_CYC    = TIMEOUT_MS * CLK_MHZ * 1000;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] OFS_CMD      = 8'hb0;
	localparam logic [7:0] OFS_DATA     = 8'hb4;
	localparam logic [7:0] OFS_IRQ_STAT = 8'hb8;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hbc;
	localparam int BIT_BUSY   = 31;
	localparam int CMD_LSB    = 28;
	localparam int BIT_TMO    = 9;
	localparam int BIT_LOADED = 8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_TMO    = 1;
	localparam int IRQ_LOADED = 2;
	localparam logic [2:0] RST_IRQ = 3'h0;
	// ****************************************
	// Commands
	// ****************************************
	localparam logic [2:0] CMD_READ   = 3'h0;
	localparam logic [2:0] CMD_PROG_DIS  = 3'h1;
	localparam logic [2:0] CMD_PROG_EN   = 3'h2;
	localparam logic [2:0] CMD_WRITE     = 3'h3;
	localparam logic [2:0] CMD_PROG_ALL  = 3'h4;
	localparam logic [2:0] CMD_ERASE     = 3'h5;
	localparam logic [2:0] CMD_ERASE_ALL = 3'h6;
	localparam logic [2:0] CMD_RELOAD = 3'h7;
	localparam logic [7:0] SIG_BYTE   = 8'ha5;
	localparam logic [2:0] LOAD_LAST  = 3'h6;
	localparam logic [4:0] FRAME_LONG  = 5'h13;
	localparam logic [4:0] FRAME_SHORT = 5'h0b;
	localparam logic [4:0] DATA_BITS   = 5'h08;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [2:0] cmd;
		logic [7:0] addr;
		logic [7:0] data;
	} src_op_t;
	typedef struct packed {
		logic cs;
		logic sclk;
		logic dout;
		logic doe;
	} src_pins_t;
	typedef enum logic [2:0] {ENG_IDLE, ENG_OUT, ENG_IN, ENG_GAP, ENG_WAIT, ENG_DONE} src_eng_st_t;
	typedef enum logic [2:0] {TOP_BOOT, TOP_IDLE, TOP_RUN, TOP_LD_RD, TOP_LD_WAIT} src_top_st_t;
endpackage
`default_nettype wire

// File: src_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module src_sync2 (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule // src_sync2
`default_nettype wire

// File: src_serial_engine.sv
`timescale 1ns/1ps
`default_nettype none
module src_serial_engine import src_pkg::*; #(
	parameter int TMO_CYC = TIMEOUT_CYC
) (
	input  wire logic    mclk,
	input  wire logic    rst_n,
	input  wire logic    start,
	input  wire src_op_t op,
	input  wire logic    sdi,
	output logic         done,
	output logic         tmo,
	output logic [7:0]   rdata,
	output src_pins_t    pins
);
	src_eng_st_t st_ff;
	logic [4:0]  div_ff;
	logic [4:0]  cnt_ff;
	logic [18:0] tx_ff;
	logic        rd_ff;
	logic        wait_ff;
	logic [22:0] tmo_cnt_ff;
	logic        tick;

	function automatic logic [18:0] frame(input src_op_t o);
		case (o.cmd)
			CMD_WRITE: frame = {1'b1, 2'h1, o.addr, o.data};
			CMD_ERASE: frame = {1'b1, 2'h3, o.addr, 8'h00};
			CMD_PROG_EN:   frame = {1'b1, 2'h0, 8'hc0, 8'h00};
			CMD_PROG_DIS:  frame = {1'b1, 2'h0, 8'h00, 8'h00};
			CMD_ERASE_ALL: frame = {1'b1, 2'h0, 8'h80, 8'h00};
			CMD_PROG_ALL:  frame = {1'b1, 2'h0, 8'h40, o.data};
			default:   frame = {1'b1, 2'h2, o.addr, 8'h00};
		endcase
	endfunction

	assign tick = (div_ff == 5'h00);

	// Link clock divider, free while a frame runs
	always_ff @(posedge mclk) begin
		if (!rst_n || st_ff == ENG_IDLE)
			div_ff <= 5'(HALF_CYC - 1);
		else if (tick)
			div_ff <= 5'(HALF_CYC - 1);
		else
			div_ff <= div_ff - 5'h01;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff      <= ENG_IDLE;
			pins       <= '0;
			tx_ff      <= '0;
			cnt_ff     <= '0;
			rd_ff      <= 1'b0;
			wait_ff    <= 1'b0;
			rdata      <= RST_BYTE;
			tmo        <= 1'b0;
			done       <= 1'b0;
			tmo_cnt_ff <= '0;
		end else begin
			done <= 1'b0;
			case (st_ff)
				ENG_IDLE: if (start) begin
					tx_ff     <= frame(op);
					pins.dout <= 1'b1;
					pins.cs   <= 1'b1;
					pins.doe  <= 1'b1;
					cnt_ff    <= (op.cmd == CMD_WRITE || op.cmd == CMD_PROG_ALL) ? FRAME_LONG : FRAME_SHORT;
					rd_ff     <= (op.cmd == CMD_READ);
					// Only write, program-all, erase and erase-all poll for ready, so nothing else can time out
					wait_ff   <= (op.cmd == CMD_WRITE || op.cmd == CMD_PROG_ALL ||
					              op.cmd == CMD_ERASE || op.cmd == CMD_ERASE_ALL);
					tmo       <= 1'b0;
					st_ff     <= ENG_OUT;
				end
				ENG_OUT: if (tick) begin
					pins.sclk <= ~pins.sclk;
					if (pins.sclk) begin
						tx_ff     <= {tx_ff[17:0], 1'b0};
						pins.dout <= tx_ff[17];
						cnt_ff    <= cnt_ff - 5'h01;
						if (cnt_ff == 5'h01) begin
							pins.doe <= 1'b0;
							if (rd_ff) begin
								cnt_ff <= DATA_BITS;
								st_ff  <= ENG_IN;
							end else if (wait_ff) begin
								pins.cs <= 1'b0;
								st_ff   <= ENG_GAP;
							end else
								st_ff <= ENG_DONE;
						end
					end
				end
				ENG_IN: if (tick) begin
					pins.sclk <= ~pins.sclk;
					if (!pins.sclk)
						rdata <= {rdata[6:0], sdi};
					else begin
						cnt_ff <= cnt_ff - 5'h01;
						if (cnt_ff == 5'h01)
							st_ff <= ENG_DONE;
					end
				end
				ENG_GAP: if (tick) begin
					pins.cs    <= 1'b1;
					tmo_cnt_ff <= '0;
					st_ff      <= ENG_WAIT;
				end
				ENG_WAIT: begin
					// Line settles half a link period before ready counts; pulled high reads ready
					if (sdi && tmo_cnt_ff >= 23'(HALF_CYC))
						st_ff <= ENG_DONE;
					else if (tmo_cnt_ff == 23'(TMO_CYC - 1)) begin
						tmo   <= 1'b1;
						st_ff <= ENG_DONE;
					end else
						tmo_cnt_ff <= tmo_cnt_ff + 23'h00_0001;
				end
				ENG_DONE: begin
					pins  <= '0;
					done  <= 1'b1;
					st_ff <= ENG_IDLE;
				end
				default: st_ff <= ENG_IDLE;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_WAIT_ONLY_PROG: assert property (st_ff == ENG_WAIT |-> wait_ff)
		else $error("ready poll on a non-programming command");
	AST_HIGH_NO_TMO: assert property (st_ff == ENG_WAIT && sdi && tmo_cnt_ff >= 23'(HALF_CYC)
		|=> st_ff == ENG_DONE ##1 done && !tmo)
		else $error("ready line high did not end the command cleanly");
	AST_TMO_BOUND: assert property (st_ff == ENG_WAIT |-> tmo_cnt_ff < 23'(TMO_CYC))
		else $error("wait counter ran past the time-out");
endmodule // src_serial_engine
`default_nettype wire

// File: src_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module src_rom_model #(
	parameter int PROG_CYC = 60
) (
	input  wire logic mclk,
	input  wire logic present,
	input  wire logic cs,
	input  wire logic sclk,
	input  wire logic din,
	output logic      dq_o,
	output logic      dq_oe
);
	logic [7:0] mem [256];
	logic [7:0] adr_ff, rd_ff, busy_ff;
	logic [9:0] sh_ff;
	logic [4:0] cnt_ff;
	logic [1:0] op_ff;
	logic       sclk_ff, cs_ff, rd_on_ff, pend_ff, stat_ff, ew_ff;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'hff;
		mem[0] = 8'ha5;
		for (int i = 1; i < 7; i++) mem[i] = 8'(i * 17);
		{sclk_ff, cs_ff, rd_on_ff, pend_ff, stat_ff, ew_ff} = '0;
		{cnt_ff, busy_ff, dq_o, dq_oe} = '0;
	end
	// ********
	// Frame decode on sclk rise, reply on fall
	// ********
	always @(posedge mclk) begin
		sclk_ff <= sclk;
		cs_ff <= cs;
		if (cs_ff && !cs) begin
			stat_ff <= pend_ff;
			pend_ff <= 1'b0;
			busy_ff <= 8'(PROG_CYC);
			rd_on_ff <= 1'b0;
			cnt_ff <= '0;
		end
		if (!present || !cs) begin
			dq_oe <= 1'b0;
		end else if (stat_ff) begin
			// Busy low, then ready high while selected
			dq_oe <= 1'b1;
			dq_o <= (busy_ff == 8'h00);
			if (busy_ff != 8'h00) busy_ff <= busy_ff - 8'h01;
		end else if (!sclk && sclk_ff && rd_on_ff) begin
			dq_oe <= 1'b1;
			dq_o <= rd_ff[7];
			rd_ff <= rd_ff << 1;
		end
		if (cs && !stat_ff && sclk && !sclk_ff) begin
			cnt_ff <= cnt_ff + 5'h01;
			sh_ff <= {sh_ff[8:0], din};
			if (cnt_ff == 5'h0a) begin
				op_ff <= sh_ff[8:7];
				adr_ff <= {sh_ff[6:0], din};
				case (sh_ff[8:7])
					2'b10: begin
						rd_on_ff <= 1'b1;
						rd_ff <= mem[{sh_ff[6:0], din}];
					end
					2'b11: begin
						pend_ff <= 1'b1;
						if (ew_ff) mem[{sh_ff[6:0], din}] <= 8'hff;
					end
					2'b00: begin
						if (sh_ff[6:5] == 2'b11) ew_ff <= 1'b1;
						if (sh_ff[6:5] == 2'b00) ew_ff <= 1'b0;
						if (sh_ff[6:5] == 2'b10) begin
							pend_ff <= 1'b1;
							for (int i = 0; i < 256; i++) if (ew_ff) mem[i] <= 8'hff;
						end
					end
					default: ;
				endcase
			end
			if (cnt_ff == 5'h12 && (op_ff == 2'b01 || (op_ff == 2'b00 && adr_ff[7:6] == 2'b01))) begin
				pend_ff <= 1'b1;
				for (int i = 0; i < 256; i++) begin
					if (ew_ff && (op_ff == 2'b00 || i == int'(adr_ff))) mem[i] <= {sh_ff[6:0], din};
				end
			end
		end
	end
endmodule // src_rom_model
`default_nettype wire

// File: src_rom_cmd_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module src_rom_cmd_engine_tb_top import src_pkg::*;;
	localparam int TMO = 200;
	logic        mclk, rst_n, cyc, stb, we, ack, line, d_o, d_oe, m_o, m_oe, cs, sclk, irq, pull_hi, present;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o, rdat;
	logic [47:0] stn;
	int          fail_count, comparisons;
	// Wire level from every party's enable; released line floats to the pull
	assign line = d_oe ? d_o : (m_oe ? m_o : pull_hi);
	src_rom_cmd_engine #(.TMO_CYC(TMO)) u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.rom_serial_data_line_i(line), .rom_serial_data_line_o(d_o), .rom_serial_data_line_oe(d_oe),
		.rom_cs(cs), .rom_sclk(sclk), .station_addr(stn), .irq(irq));
	src_rom_model u_rom (.mclk(mclk), .present(present), .cs(cs), .sclk(sclk), .din(d_o), .dq_o(m_o),
		.dq_oe(m_oe));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ********
	// Bus and check tasks
	// ********
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		{cyc, stb, we} <= 3'b000;
		chk(n < 50, 1'b1, "no ack");
	endtask
	task automatic idle();
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_CMD, 32'h0000_0000, 4'hf);
			n++;
		end while (rdat[31] !== 1'b0 && n < 2000);
		chk(n < 2000, 1'b1, "stuck busy");
	endtask
	task automatic run(input logic [2:0] c, input logic [7:0] a);
		bus(1'b1, OFS_CMD, {1'b1, c, 20'h0_0000, a}, 4'b1001);
		bus(1'b0, OFS_CMD, 32'h0000_0000, 4'hf);
		chk(rdat[31], 1'b1, "busy after go");
		idle();
	endtask
	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ********
	// Watchdog
	// ********
	initial begin
		#400_000;
		fail_count++;
		$display("ERROR t=%0t watchdog", $time);
		give_verdict();
	end
	// ********
	// Tests
	// ********
	initial begin
		{cyc, stb, we, adr, dat, sel, rst_n, fail_count, comparisons} = '0;
		{pull_hi, present} = 2'b11;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		idle();
		chk(rdat[9:0], 10'h100, "boot flags");
		chk(stn, 48'h6655_4433_2211, "station id");
		bus(1'b0, OFS_DATA, 32'h0000_0000, 4'hf);
		chk(rdat, 32'h0000_0000, "data reset");
		$display("test boot done");
		bus(1'b1, OFS_DATA, 32'hffff_ff5a, 4'hf);
		bus(1'b0, OFS_DATA, 32'h0000_0000, 4'hf);
		chk(rdat, 32'h0000_005a, "data rw");
		run(CMD_READ, 8'h06);
		chk(rdat[7:0], 8'h06, "addr field");
		bus(1'b0, OFS_DATA, 32'h0000_0000, 4'hf);
		chk(rdat, 32'h0000_0066, "read byte");
		$display("test read done");
		run(CMD_PROG_EN, 8'h00);
		bus(1'b1, OFS_DATA, 32'h0000_003c, 4'hf);
		bus(1'b1, OFS_CMD, {1'b1, CMD_WRITE, 20'h0_0000, 8'hfe}, 4'b1001);
		bus(1'b1, OFS_DATA, 32'h0000_0077, 4'hf);
		bus(1'b1, OFS_CMD, {1'b1, CMD_ERASE, 20'h0_0000, 8'h11}, 4'b1001);
		idle();
		chk(rdat[9], 1'b0, "write no timeout");
		chk({rdat[30:28], rdat[7:0]}, {CMD_WRITE, 8'hfe}, "busy command write ignored");
		run(CMD_READ, 8'hfe);
		bus(1'b0, OFS_DATA, 32'h0000_0000, 4'hf);
		chk(rdat, 32'h0000_003c, "program readback");
		$display("test program done");
		bus(1'b1, OFS_CMD, 32'h0000_0100, 4'b0010);
		bus(1'b0, OFS_CMD, 32'h0000_0000, 4'hf);
		chk(rdat[8], 1'b0, "loaded cleared");
		run(CMD_RELOAD, 8'h00);
		chk(rdat[8], 1'b1, "loaded on reload");
		$display("test reload done");
		{present, pull_hi} <= 2'b00;
		bus(1'b1, OFS_IRQ_STAT, 32'h0000_0007, 4'hf);
		for (int i = 0; i < 8; i++) begin
			run(3'(i), 8'h20);
			chk(rdat[9], (i >= 3 && i <= 6), "absent low timeout");
		end
		chk(irq, 1'b0, "irq masked");
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002, 4'hf);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1, "irq raised");
		bus(1'b1, OFS_IRQ_STAT, 32'h0000_0002, 4'hf);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0, "irq cleared");
		$display("test absent low done");
		pull_hi <= 1'b1;
		bus(1'b1, OFS_CMD, 32'h0000_0100, 4'b0010);
		for (int i = 0; i < 8; i++) begin
			run(3'(i), 8'h20);
			chk(rdat[9], 1'b0, "absent high no timeout");
		end
		chk(rdat[8], 1'b0, "bad signature not loaded");
		$display("test absent high done");
		give_verdict();
	end
endmodule // src_rom_cmd_engine_tb_top
`default_nettype wire
